// [verilog/mmrc_map.vh]
// Purpose: constants for the memory map / refresh configuration block
// Assumes: 125 MHz clk, indexed configuration port pair
// Notes:   definitions only
`ifndef MMRC_MAP_VH
`define MMRC_MAP_VH

// ----------------------------------------------------------------
// configuration ports and indices
// ----------------------------------------------------------------
`define MMRC_PORT_INDEX      8'hEC
`define MMRC_PORT_DATA       8'hED
`define MMRC_IDX_SLOTPTR     8'h02
`define MMRC_IDX_DRAMMAP     8'h03
`define MMRC_IDX_DRAMCTL     8'h05
`define MMRC_IDX_REFRESH_SUSPEND_CONTROL      8'h06

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MMRC_CTL_PAGEOFF     2
`define MMRC_CTL_PARITYOFF   1
`define MMRC_CTL_ROWSHUT     0
`define MMRC_MAP_ROMMOV_HI   6
`define MMRC_MAP_ROMMOV_LO   5
`define MMRC_MAP_REMAP       4
`define MMRC_REF_SUSPARM     7
`define MMRC_REF_CPUOFF      6
`define MMRC_REF_CPU_RESET_REQUEST_FLAG      5
`define MMRC_REF_HALT        4
`define MMRC_REF_KIND_HI     3
`define MMRC_REF_KIND_LO     2
`define MMRC_REF_PER_HI      1
`define MMRC_REF_PER_LO      0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MMRC_RST_SLOTPTR     8'hFF
`define MMRC_RST_REFRESH_SUSPEND_CONTROL      8'h00
`define MMRC_RST_DRAMCTL     8'h00
`define MMRC_RST_DRAMMAP     8'h00

// ----------------------------------------------------------------
// refresh encodings and timing
// ----------------------------------------------------------------
`define MMRC_KIND_RASONLY    2'h0
`define MMRC_KIND_CBR        2'h1
`define MMRC_KIND_SELF       2'h2
`define MMRC_KIND_NONE       2'h3
`define MMRC_PER_STD         2'h0
`define MMRC_PER_SLOW        2'h1
`define MMRC_PER_SLOWER      2'h2
`define MMRC_PER_RSVD        2'h3
// periods in ps, base tick is one standard period
`define MMRC_T_STD_PS        15625000
`define MMRC_T_SLOW_PS       125000000
`define MMRC_T_SLOWER_PS     250000000
// 32 kHz tick period in ps (31.25 us)
`define MMRC_T_RTC_PS        31250000
`define MMRC_RESET_PULSE     16

// ----------------------------------------------------------------
// address map, 64K segment numbers
// ----------------------------------------------------------------
`define MMRC_SEG_640K        8'h0A
`define MMRC_SEG_1M          8'h10
`define MMRC_SEG_C           8'h0C
`define MMRC_SEG_D           8'h0D
`define MMRC_SEG_E           8'h0E
`define MMRC_SEG_F           8'h0F
`define MMRC_SEG_ROMTOP      8'hFE
`define MMRC_PTR_SLOTMAX     8'hFD
`define MMRC_REMAP_BASE      24'h0A_0000
`define MMRC_REMAP_SIZE      24'h06_0000
`define MMRC_SHD_NORMAL      2'h0
`define MMRC_SHD_SETUP       2'h1
`define MMRC_SHD_RDBOARD     2'h2
`define MMRC_SHD_BOARD       2'h3

`endif

// [verilog/mmrc_refresh_tick.v]
// Purpose: refresh request pacing from the timer or 32 kHz time base
// Assumes: base pulses are one clk wide and synchronous
// Notes:   reserved period code behaves as the standard period
`timescale 1ns/1ns
`include "mmrc_map.vh"

module mmrc_refresh_tick #(
   parameter CW = 5
) (
   // clock and reset
   input  wire          clk,
   input  wire          rst,
   // time bases
   input  wire          timerPulse,
   input  wire          rtcTick,
   input  wire          useRtc,
   input  wire [1:0]    periodSel,
   // request
   output reg           refreshDue
);

   // ----------------------------------------------------------------
   // divisors, at least one base pulse each
   // ----------------------------------------------------------------
   localparam integer TIM_SLOW   = `MMRC_T_SLOW_PS / `MMRC_T_STD_PS;
   localparam integer TIM_SLOWER = `MMRC_T_SLOWER_PS / `MMRC_T_STD_PS;
   localparam integer RTC_STD_R  = `MMRC_T_STD_PS / `MMRC_T_RTC_PS;
   localparam integer RTC_STD    = (RTC_STD_R < 1) ? 1 : RTC_STD_R;
   localparam integer RTC_SLOW   = `MMRC_T_SLOW_PS / `MMRC_T_RTC_PS;
   localparam integer RTC_SLOWER = `MMRC_T_SLOWER_PS / `MMRC_T_RTC_PS;

   reg  [CW-1:0] count;
   reg  [CW-1:0] limit;
   wire          baseTick = useRtc ? rtcTick : timerPulse;

   always @* begin
      case (periodSel)
         `MMRC_PER_SLOW:   limit = useRtc ? RTC_SLOW[CW-1:0] : TIM_SLOW[CW-1:0];
         `MMRC_PER_SLOWER: limit = useRtc ? RTC_SLOWER[CW-1:0] : TIM_SLOWER[CW-1:0];
         default:          limit = useRtc ? RTC_STD[CW-1:0] : {{(CW-1){1'b0}}, 1'b1};
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count      <= {CW{1'b0}};
         refreshDue <= 1'b0;
      end else begin
         refreshDue <= 1'b0;
         if (baseTick) begin
            if (count + {{(CW-1){1'b0}}, 1'b1} >= limit) begin
               count      <= {CW{1'b0}};
               refreshDue <= 1'b1;
            end else begin
               count <= count + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // mmrc_refresh_tick

// [verilog/mmrc_memory_map_refresh_config.v]
// Purpose: memory configuration registers, refresh control, address decode
// Assumes: all inputs synchronous to clk, straps stable across reset
// Notes:   decode answers one clk after cpuCycle; straps load after reset
`timescale 1ns/1ns
`include "mmrc_map.vh"

module mmrc_memory_map_refresh_config #(
   parameter RST_CYCLES = `MMRC_RESET_PULSE
) (
   // clock and reset
   input  wire          clk,
   input  wire          rst,
   // configuration i/o port
   input  wire [7:0]    ioAddr,
   input  wire          ioWr,
   input  wire          ioRd,
   input  wire [7:0]    ioWrData,
   output reg  [7:0]    ioRdData,
   // straps sampled after reset
   input  wire          pageModeStrap,
   input  wire          romMoveStrapHi,
   input  wire          romMoveStrapLo,
   input  wire          remapStrap,
   input  wire          romLocStrap,
   input  wire          romWidthStrap,
   // cpu cycle
   input  wire          cpuCycle,
   input  wire [23:0]   cpuAddr,
   input  wire          cpuWrite,
   input  wire          haltCycle,
   input  wire          intAckCycle,
   input  wire          nmi,
   input  wire          sysResetN,
   // reset requests
   input  wire          kbdResetReq,
   input  wire          portAResetReq,
   input  wire          featureResetReq,
   // suspend and time bases
   input  wire          suspendReqN,
   input  wire          hlda,
   input  wire          refreshTimerPulse,
   input  wire          rtcTick,
   // memory sizing and shadow controls
   input  wire [2:0]    totalDramMeg,
   input  wire [7:0]    shadowCtlVideoSeg,
   input  wire [7:0]    shadowCtlCSeg,
   input  wire [7:0]    shadowCtlDSeg,
   input  wire [7:0]    shadowCtlEfSeg,
   // dram control
   output wire          pageModeEnable,
   output wire          parityEnable,
   output wire          singleRowStrobe,
   output wire          bankSelectEnable,
   // refresh
   output reg           refreshReq,
   output wire          refreshCasFirst,
   output reg           selfRefreshHold,
   // suspend
   output reg           suspendActive,
   output wire          clocksStopped,
   output wire          leakageCtl,
   output wire          cpuOffPinState,
   output wire          cpuResetOut,
   output wire          coprocResetOut,
   // decode
   output reg           decValid,
   output reg           decDram,
   output reg           decSlot,
   output reg           decRom,
   output reg  [23:0]   dramAddr,
   output reg           romSelectN,
   output reg           romOnLocalBus,
   output reg           romWide,
   output wire          remapActive
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [7:0]  cfgIndex;
   reg  [7:0]  slotBoundaryPointer;
   reg  [7:0]  refreshSuspendControl;
   reg  [7:0]  dramControl;
   reg  [7:0]  dramMap;
   reg         strapLoad;
   reg         cpuResetRequestFlag;
   reg         haltSeenFlag;
   reg         nmiPrev;
   reg         cpuResetPrev;
   reg         cbrDoneInSus;
   reg  [4:0]  resetCount;

   wire        wrIndex  = ioWr && (ioAddr == `MMRC_PORT_INDEX);
   wire        wrData   = ioWr && (ioAddr == `MMRC_PORT_DATA) && !strapLoad;
   wire        suspendArm      = refreshSuspendControl[`MMRC_REF_SUSPARM];
   wire        cpuOffInSuspend = refreshSuspendControl[`MMRC_REF_CPUOFF];
   wire [1:0]  refreshKindSel  = refreshSuspendControl[`MMRC_REF_KIND_HI:`MMRC_REF_KIND_LO];
   wire [1:0]  refreshPeriodSel = refreshSuspendControl[`MMRC_REF_PER_HI:`MMRC_REF_PER_LO];
   wire [1:0]  romRelocateSel  = dramMap[`MMRC_MAP_ROMMOV_HI:`MMRC_MAP_ROMMOV_LO];
   wire        upperRegionRemap = dramMap[`MMRC_MAP_REMAP];
   wire        anyResetReq = kbdResetReq | portAResetReq | featureResetReq;
   wire        cpuResetRise = cpuResetOut && !cpuResetPrev;

   // page mode off when bit set
   assign pageModeEnable   = !dramControl[`MMRC_CTL_PAGEOFF];
   assign parityEnable     = !dramControl[`MMRC_CTL_PARITYOFF];
   // one row strobe on bank miss
   assign singleRowStrobe  = dramControl[`MMRC_CTL_ROWSHUT];
   assign bankSelectEnable = (slotBoundaryPointer != 8'h00);

   // ----------------------------------------------------------------
   // register writes and strap capture
   // ----------------------------------------------------------------
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgIndex              <= 8'h00;
         slotBoundaryPointer   <= `MMRC_RST_SLOTPTR;
         refreshSuspendControl <= `MMRC_RST_REFRESH_SUSPEND_CONTROL;
         dramControl           <= `MMRC_RST_DRAMCTL;
         dramMap               <= `MMRC_RST_DRAMMAP;
         strapLoad             <= 1'b1;
         romOnLocalBus         <= 1'b0;
         romWide               <= 1'b0;
      end else begin
         strapLoad <= 1'b0;
         if (strapLoad) begin
            dramControl[`MMRC_CTL_PAGEOFF]   <= pageModeStrap;
            dramMap[`MMRC_MAP_ROMMOV_HI]     <= romMoveStrapHi;
            dramMap[`MMRC_MAP_ROMMOV_LO]     <= romMoveStrapLo;
            dramMap[`MMRC_MAP_REMAP]         <= remapStrap;
            romOnLocalBus <= romLocStrap;
            romWide       <= romWidthStrap;
         end
         if (wrIndex)
            cfgIndex <= ioWrData;
         if (wrData) begin
            case (cfgIndex)
               `MMRC_IDX_SLOTPTR: slotBoundaryPointer <= ioWrData;
               `MMRC_IDX_DRAMCTL: dramControl <= ioWrData;
               `MMRC_IDX_DRAMMAP: dramMap <= ioWrData;
               // status bits 5 and 4 are not writable
               `MMRC_IDX_REFRESH_SUSPEND_CONTROL: begin
                  refreshSuspendControl[`MMRC_REF_SUSPARM:`MMRC_REF_CPUOFF] <=
                     ioWrData[`MMRC_REF_SUSPARM:`MMRC_REF_CPUOFF];
                  refreshSuspendControl[`MMRC_REF_KIND_HI:`MMRC_REF_PER_LO] <=
                     ioWrData[`MMRC_REF_KIND_HI:`MMRC_REF_PER_LO];
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   reg [7:0] refRead;
   always @* begin
      refRead = refreshSuspendControl;
      refRead[`MMRC_REF_CPU_RESET_REQUEST_FLAG] = cpuResetRequestFlag;
      refRead[`MMRC_REF_HALT]   = haltSeenFlag;
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ioRdData <= 8'h00;
      end else if (ioRd) begin
         if (ioAddr == `MMRC_PORT_INDEX)
            ioRdData <= cfgIndex;
         else if (ioAddr == `MMRC_PORT_DATA) begin
            case (cfgIndex)
               `MMRC_IDX_SLOTPTR: ioRdData <= slotBoundaryPointer;
               `MMRC_IDX_DRAMCTL: ioRdData <= dramControl;
               `MMRC_IDX_DRAMMAP: ioRdData <= dramMap;
               `MMRC_IDX_REFRESH_SUSPEND_CONTROL:  ioRdData <= refRead;
               default:           ioRdData <= 8'h00;
            endcase
         end else
            ioRdData <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // status flags, suspend and cpu reset
   // ----------------------------------------------------------------
   wire suspendEnter = suspendArm && !suspendReqN && hlda && !suspendActive;
   wire suspendExit  = suspendActive && (suspendReqN || !suspendArm);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cpuResetRequestFlag <= 1'b0;
         haltSeenFlag        <= 1'b0;
         nmiPrev             <= 1'b0;
         cpuResetPrev        <= 1'b0;
         suspendActive       <= 1'b0;
         resetCount          <= 5'h00;
      end else begin
         nmiPrev      <= nmi;
         cpuResetPrev <= cpuResetOut;
         if (anyResetReq)
            cpuResetRequestFlag <= 1'b1;
         else if (cpuResetRise)
            cpuResetRequestFlag <= 1'b0;
         if (haltCycle)
            haltSeenFlag <= 1'b1;
         else if (!sysResetN || cpuResetOut || (nmi && !nmiPrev) || intAckCycle)
            haltSeenFlag <= 1'b0;
         if (suspendEnter)
            suspendActive <= 1'b1;
         else if (suspendExit)
            suspendActive <= 1'b0;
         if ((suspendExit && cpuOffInSuspend) || anyResetReq)
            resetCount <= RST_CYCLES[4:0];
         else if (resetCount != 5'h00)
            resetCount <= resetCount - 5'h01;
      end
   end

   assign cpuResetOut    = (resetCount != 5'h00);
   assign coprocResetOut = cpuResetOut;
   assign clocksStopped  = suspendActive;
   assign leakageCtl     = suspendActive;
   assign cpuOffPinState = suspendActive && cpuOffInSuspend;

   // ----------------------------------------------------------------
   // refresh
   // ----------------------------------------------------------------
   wire refreshDue;

   // 32 kHz time base in suspend
   mmrc_refresh_tick #(
      .CW         (5)
   ) uTick (
      .clk        (clk),
      .rst        (rst),
      .timerPulse (refreshTimerPulse),
      .rtcTick    (rtcTick),
      .useRtc     (suspendActive),
      .periodSel  (refreshPeriodSel),
      .refreshDue (refreshDue)
   );

   assign refreshCasFirst = (refreshKindSel == `MMRC_KIND_CBR) || (refreshKindSel == `MMRC_KIND_SELF);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         refreshReq      <= 1'b0;
         selfRefreshHold <= 1'b0;
         cbrDoneInSus    <= 1'b0;
      end else begin
         refreshReq <= refreshDue && (refreshKindSel != `MMRC_KIND_NONE) && !selfRefreshHold;
         if (!suspendActive) begin
            selfRefreshHold <= 1'b0;
            cbrDoneInSus    <= 1'b0;
         end else if (refreshKindSel == `MMRC_KIND_SELF) begin
            if (refreshReq)
               cbrDoneInSus <= 1'b1;
            if (cbrDoneInSus)
               selfRefreshHold <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire [7:0]  seg = cpuAddr[23:16];
   wire [7:0]  effPtr = (slotBoundaryPointer >= `MMRC_SEG_640K && slotBoundaryPointer < `MMRC_SEG_1M) ?
                        `MMRC_SEG_1M : slotBoundaryPointer;
   // remap only for 1M to 4M totals
   wire        sizeOk  = (totalDramMeg != 3'h0) && (totalDramMeg <= 3'h4);
   assign remapActive  = upperRegionRemap && sizeOk;
   wire [23:0] memTop  = {1'b0, totalDramMeg, 20'h0_0000};
   wire        remapHit = remapActive && (cpuAddr >= memTop) && (cpuAddr < memTop + `MMRC_REMAP_SIZE);

   reg  [1:0]  shdMode;
   reg         romDefault;
   reg         tDram;
   reg         tSlot;
   reg         tRom;

   always @* begin
      case (seg[3:0])
         4'hA, 4'hB: shdMode = shadowCtlVideoSeg[{seg[0], cpuAddr[15]}*2 +: 2];
         4'hC:       shdMode = shadowCtlCSeg[cpuAddr[15:14]*2 +: 2];
         4'hD:       shdMode = shadowCtlDSeg[cpuAddr[15:14]*2 +: 2];
         default:    shdMode = shadowCtlEfSeg[{seg[0], cpuAddr[15]}*2 +: 2];
      endcase
      // relocation of C and E segments
      case (seg)
         `MMRC_SEG_C: romDefault = cpuAddr[15] ? (romRelocateSel == 2'h3) : romRelocateSel[1];
         `MMRC_SEG_E: romDefault = cpuAddr[15] ? !romRelocateSel[0] : (romRelocateSel == 2'h0);
         `MMRC_SEG_F: romDefault = 1'b1;
         default:     romDefault = 1'b0;
      endcase
      tDram = 1'b0;
      tSlot = 1'b0;
      tRom  = 1'b0;
      if (remapHit) begin
         tDram = 1'b1;
      end else if (seg >= `MMRC_SEG_ROMTOP) begin
         tRom = 1'b1;
      end else if (seg < `MMRC_SEG_640K) begin
         if (effPtr < `MMRC_SEG_640K && effPtr != 8'h00 && seg >= effPtr)
            tSlot = 1'b1;
         else
            tDram = 1'b1;
      end else if (seg < `MMRC_SEG_1M) begin
         if (remapActive || shdMode == `MMRC_SHD_NORMAL ||
             (shdMode == `MMRC_SHD_SETUP && !cpuWrite) ||
             (shdMode == `MMRC_SHD_RDBOARD && cpuWrite)) begin
            tRom  = romDefault;
            tSlot = !romDefault;
         end else
            tDram = 1'b1;
      end else if (effPtr < `MMRC_SEG_1M) begin
         tSlot = 1'b1;
      end else if (seg < effPtr) begin
         tDram = 1'b1;
      end else if (effPtr <= `MMRC_PTR_SLOTMAX) begin
         tSlot = 1'b1;
      end else begin
         tRom = 1'b1;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         decValid   <= 1'b0;
         decDram    <= 1'b0;
         decSlot    <= 1'b0;
         decRom     <= 1'b0;
         dramAddr   <= 24'h00_0000;
         romSelectN <= 1'b1;
      end else begin
         decValid <= cpuCycle;
         // no dram cycle with zero pointer
         decDram  <= cpuCycle && tDram && bankSelectEnable;
         decSlot  <= cpuCycle && tSlot;
         decRom   <= cpuCycle && tRom;
         romSelectN <= !(cpuCycle && tRom);
         if (cpuCycle)
            dramAddr <= remapHit ? (cpuAddr - memTop + `MMRC_REMAP_BASE) : cpuAddr;
      end
   end

endmodule // mmrc_memory_map_refresh_config

// [sim/mmrc_time_base.sv]
// Purpose: far-side time bases, timer pulse and slow 32 kHz stand-in
// Assumes: one-clk pulses, both shortened to keep runs short
// Notes:   periods are parameters, not real rates
`timescale 1ns/1ns
module mmrc_time_base #(parameter TP = 4, RP = 16) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pulses
   output wire logic refreshTimerPulse,
   output wire logic rtcTick
);
   int n;
   always @(posedge clk or posedge rst)
      if (rst) n <= 0;
      else n <= n + 1;
   assign refreshTimerPulse = !rst && n % TP == 0;
   assign rtcTick = !rst && n % RP == 0;
endmodule // mmrc_time_base

// [sim/mmrc_map_chk.sv]
// Purpose: port assertions for the memory map block
// Assumes: one clock domain, rst async high
// Notes:   bound to the top module below
`timescale 1ns/1ns
module mmrc_map_chk #(parameter RST_CYCLES = 16) (
   // clock, cycle, decode, suspend
   input wire logic clk, rst, cpuCycle, decValid, decDram, decSlot, decRom, romSelectN,
   input wire logic [23:0] cpuAddr,
   input wire logic bankSelectEnable, suspendActive, clocksStopped, leakageCtl, suspendReqN, hlda,
   input wire logic cpuResetOut, selfRefreshHold, refreshReq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // length of the current reset pulse
   int hiCnt;
   always @(posedge clk or posedge rst)
      if (rst) hiCnt <= 0;
      else hiCnt <= cpuResetOut ? hiCnt + 1 : 0;
   property p_dec; decValid |-> $past(cpuCycle); endproperty
   a_dec: assert property (p_dec) else $error("decode without cycle");
   property p_top; cpuCycle && cpuAddr[23:17] == 7'h7F |=> decRom && !decDram && !decSlot; endproperty
   a_top: assert property (p_top) else $error("top segments not rom");
   property p_rom; decRom |-> !romSelectN; endproperty
   a_rom: assert property (p_rom) else $error("rom select missing");
   property p_bank; decDram |-> bankSelectEnable; endproperty
   a_bank: assert property (p_bank) else $error("dram with banks off");
   property p_pwr; clocksStopped == suspendActive && leakageCtl == suspendActive; endproperty
   a_pwr: assert property (p_pwr) else $error("suspend outputs split");
   property p_enter; $rose(suspendActive) |-> !$past(suspendReqN) && $past(hlda); endproperty
   a_enter: assert property (p_enter) else $error("suspend without request");
   property p_self; selfRefreshHold |-> !refreshReq; endproperty
   a_self: assert property (p_self) else $error("refresh during hold");
   property p_rst; $fell(cpuResetOut) |-> hiCnt == RST_CYCLES; endproperty
   a_rst: assert property (p_rst) else $error("cpu reset length");
endmodule // mmrc_map_chk

bind mmrc_memory_map_refresh_config mmrc_map_chk #(.RST_CYCLES(RST_CYCLES)) i_mmrc_map_chk (
   .clk, .rst, .cpuCycle, .decValid, .decDram, .decSlot, .decRom, .romSelectN, .cpuAddr,
   .bankSelectEnable, .suspendActive, .clocksStopped, .leakageCtl, .suspendReqN, .hlda,
   .cpuResetOut, .selfRefreshHold, .refreshReq);

// [sim/mmrc_memory_map_refresh_config_tb.sv]
// Purpose: self-checking bench for the memory map block
// Assumes: reset pulse shortened to 4 clocks
// Notes:   random pointers and segments from a fixed seed
`timescale 1ns/1ns
module mmrc_memory_map_refresh_config_tb;
   logic clk = 0, rst = 1, ioWr = 0, ioRd = 0, cpuCycle = 0, cpuWrite = 0, haltCycle = 0;
   logic intAckCycle = 0, nmi = 0, sysResetN = 1, hlda = 0, suspendReqN = 1;
   logic [2:0] req = 0, totalDramMeg = 2;
   logic [5:0] st = 6'h32;
   logic [7:0] ioAddr = 0, ioWrData = 0, ioRdData, p, s, shd = 0;
   logic [23:0] cpuAddr = 0, dramAddr;
   logic refreshTimerPulse, rtcTick, pageModeEnable, parityEnable, singleRowStrobe, bankSelectEnable;
   logic refreshReq, refreshCasFirst, selfRefreshHold, suspendActive, clocksStopped, leakageCtl;
   logic cpuOffPinState, cpuResetOut, coprocResetOut, decValid, decDram, decSlot, decRom;
   logic romSelectN, romOnLocalBus, romWide, remapActive;
   int errTotal = 0, cmpCount = 0, refCnt = 0, cycN = 0, e;
   logic [15:0] cn [8] = '{16'h0A10, 16'hFE80, 16'hFDFD, 16'hFDFF, 16'h0504, 16'h1010, 16'h0005, 16'h0607};
   always #4 clk = ~clk;
   mmrc_time_base i_mmrc_time_base (.clk, .rst, .refreshTimerPulse, .rtcTick);
   mmrc_memory_map_refresh_config #(.RST_CYCLES(4)) i_mmrc_memory_map_refresh_config (
      .clk, .rst, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData, .pageModeStrap(st[5]),
      .romMoveStrapHi(st[4]), .romMoveStrapLo(st[3]), .remapStrap(st[2]), .romLocStrap(st[1]),
      .romWidthStrap(st[0]), .cpuCycle, .cpuAddr, .cpuWrite, .haltCycle, .intAckCycle, .nmi,
      .sysResetN, .kbdResetReq(req[0]), .portAResetReq(req[1]), .featureResetReq(req[2]),
      .suspendReqN, .hlda, .refreshTimerPulse, .rtcTick, .totalDramMeg, .shadowCtlVideoSeg(shd),
      .shadowCtlCSeg(shd), .shadowCtlDSeg(shd), .shadowCtlEfSeg(shd), .pageModeEnable,
      .parityEnable, .singleRowStrobe, .bankSelectEnable, .refreshReq, .refreshCasFirst,
      .selfRefreshHold, .suspendActive, .clocksStopped, .leakageCtl, .cpuOffPinState, .cpuResetOut,
      .coprocResetOut, .decValid, .decDram, .decSlot, .decRom, .dramAddr, .romSelectN,
      .romOnLocalBus, .romWide, .remapActive);
   always @(posedge clk) begin
      refCnt += refreshReq;
      cycN++;
      if (cycN == 20000) begin
         errTotal++;
         tallyAndFinish();
      end
   end
   task automatic cyc();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] a, x);
      cmpCount++;
      if (a !== x) begin
         errTotal++;
         $display("wrong value at %0t: saw %h want %h", $time, a, x);
      end
   endtask
   task automatic wr(input logic [7:0] i, d);
      ioAddr = 8'hEC; ioWrData = i; ioWr = 1; cyc();
      ioAddr = 8'hED; ioWrData = d; cyc();
      ioWr = 0; cyc();
   endtask
   task automatic rd(input logic [7:0] i, x);
      ioAddr = 8'hEC; ioWrData = i; ioWr = 1; cyc();
      ioWr = 0; ioAddr = 8'hED; ioRd = 1; cyc();
      ioRd = 0; cyc();
      chk(ioRdData, x);
   endtask
   task automatic dec(input logic [23:0] a);
      cpuAddr = a; cpuWrite = 1'($urandom); cpuCycle = 1; cyc();
      cpuCycle = 0;
   endtask
   // expected {dram, slot, rom} outside the A-F segments
   function automatic logic [2:0] expDec(input logic [7:0] g, q);
      if (q > 8'h09 && q < 8'h10) q = 8'h10;
      if (g > 8'hFD) return 3'b001;
      if (g < 8'h10) return (q > 8'h03 && q < 8'h0A && g >= q) ? 3'b010 : 3'b100;
      if (q < 8'h10) return 3'b010;
      if (g < q) return 3'b100;
      return q <= 8'hFD ? 3'b010 : 3'b001;
   endfunction
   task automatic tallyAndFinish();
      if (errTotal == 0 && cmpCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      e = $urandom(61975);
      repeat (12) @(posedge clk);
      #1 rst = 0;
      cyc(); cyc();
      rd(2, 8'hFF);
      rd(5, 8'h04);
      rd(3, 8'h40);
      rd(6, 8'h00);
      chk({pageModeEnable, parityEnable, romOnLocalBus, romWide}, 4'b0110);
      wr(5, 8'h03); chk({pageModeEnable, parityEnable, singleRowStrobe}, 3'b101);
      wr(5, 8'h04); chk({pageModeEnable, parityEnable, singleRowStrobe}, 3'b010);
      for (int i = 0; i < 4; i++) begin
         wr(6, 8'(i)); refCnt = 0; repeat (512) cyc();
         e = i == 1 ? 16 : i == 2 ? 8 : 128;
         chk(refCnt >= e - 1 && refCnt <= e + 1, 1);
      end
      for (int k = 0; k < 4; k++) begin
         wr(6, 8'(k << 2)); refCnt = 0; repeat (64) cyc();
         chk({refreshCasFirst, refCnt == 0}, {k == 1 || k == 2, k == 3});
      end
      wr(6, 8'h00);
      for (int c = 0; c < 3; c++) begin
         haltCycle = 1; cyc(); haltCycle = 0;
         rd(6, 8'h10);
         intAckCycle = c == 0; nmi = c == 1; sysResetN = c != 2; cyc();
         intAckCycle = 0; sysResetN = 1; cyc(); nmi = 0;
         rd(6, 8'h00);
      end
      for (int i = 0; i < 3; i++) begin
         req = 3'(1 << i); cyc(); req = 0; ioRd = 1; cyc(); ioRd = 0;
         chk({cpuResetOut, ioRdData}, {1'b1, 8'h20});
         repeat (8) cyc();
         rd(6, 8'h00);
      end
      for (int j = 0; j < 68; j++) begin
         {p, s} = j < 8 ? cn[j] : 16'($urandom);
         if (p > 0 && p < 4) p = 8'h04;
         if (s > 8'h09 && s < 8'h10) s = 8'h10;
         wr(2, p); dec({s, 16'($urandom)});
         if (p == 0) chk({decDram, bankSelectEnable}, 0);
         else chk({decDram, decSlot, decRom}, expDec(s, p));
      end
      wr(2, 8'h40);
      for (int r = 0; r < 4; r++) begin
         wr(3, 8'(r << 5));
         dec(24'h0C_0000); chk(decRom, r > 1);
         dec(24'h0E_0000); chk(decRom, r == 0);
      end
      shd = 8'hFF; wr(3, 8'h10); chk(remapActive, 1);
      dec(24'h20_0000); chk({decDram, dramAddr}, {1'b1, 24'h0A_0000});
      dec(24'h0F_0000); chk({decDram, decRom}, 2'b01);
      totalDramMeg = 5; cyc(); chk(remapActive, 0);
      dec(24'h0F_0000); chk({decDram, decRom}, 2'b10);
      totalDramMeg = 2; shd = 8'h00; wr(3, 8'h00);
      suspendReqN = 0; hlda = 1; repeat (4) cyc();
      chk(suspendActive, 0);
      wr(6, 8'hC8); repeat (100) cyc();
      chk({suspendActive, cpuOffPinState, selfRefreshHold}, 3'b111);
      suspendReqN = 1; hlda = 0; cyc(); cyc();
      chk({suspendActive, coprocResetOut, selfRefreshHold}, 3'b010);
      tallyAndFinish();
   end
endmodule // mmrc_memory_map_refresh_config_tb
